// ### hw/itb_timer_top.sv
// host port side of the three-counter interval timer plus firmware countdown
`timescale 1ns/1ps
module itb_timer_top
  import itb_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [31:0] io_wdata_i,
  input  wire logic [3:0]  io_be_i,
  input  wire logic [2:0]  ctr_tick_i,
  input  wire logic [2:0]  ctr_out_i,
  input  wire logic        bt_tick_i,
  input  wire logic        cfg_base_wr_i,
  input  wire logic [15:0] cfg_base_data_i,
  output logic      [31:0] io_rdata_o,
  output logic             io_ack_o,
  output logic             io_isa_fwd_o,
  output logic      [15:0] cfg_base_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one step down in binary or in four-digit decimal, wrapping at zero
  function automatic itb_cnt_t itb_dec(input itb_cnt_t v, input logic bcd);
    itb_cnt_t r;
    logic     brw;
    r   = v;
    brw = 1'b1;
    if (!bcd) begin
      r = v - itb_cnt_t'(1);
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (brw) begin
          if (v[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = 4'h9;
          end else begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            brw         = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : itb_dec

  // address of counter port n
  function automatic logic [15:0] itb_port(input int n);
    logic [15:0] a;
    case (n)
      0:       a = ITB_PORT_CTR0;
      1:       a = ITB_PORT_CTR1;
      default: a = ITB_PORT_CTR2;
    endcase
    return a;
  endfunction : itb_port

  ////////////////////////////////////////////////////////////////////////////
  // reset and countdown

  logic rst_n;

  itb_rst_sync u_rst_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .rstn_o (rst_n)
  );

  itb_bt_if bt_link ();

  itb_firmware_countdown u_firmware_countdown (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .bt      (bt_link.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-counter state

  logic [1:0]  rw_ff       [ITB_NUM_CTR];
  logic [2:0]  mode_ff     [ITB_NUM_CTR];
  logic        bcd_ff      [ITB_NUM_CTR];
  itb_cnt_t    hold_ff     [ITB_NUM_CTR];
  itb_cnt_t    ce_ff       [ITB_NUM_CTR];
  logic        null_ff     [ITB_NUM_CTR];
  logic        wr_msb_ff   [ITB_NUM_CTR];
  logic        rd_msb_ff   [ITB_NUM_CTR];
  logic        cnt_lat_ff  [ITB_NUM_CTR];
  itb_cnt_t    latch_ff    [ITB_NUM_CTR];
  logic        stat_lat_ff [ITB_NUM_CTR];
  itb_byte_t   stat_ff     [ITB_NUM_CTR];

  logic [1:0]  nxt_rw       [ITB_NUM_CTR];
  logic [2:0]  nxt_mode     [ITB_NUM_CTR];
  logic        nxt_bcd      [ITB_NUM_CTR];
  itb_cnt_t    nxt_hold     [ITB_NUM_CTR];
  itb_cnt_t    nxt_ce       [ITB_NUM_CTR];
  logic        nxt_null     [ITB_NUM_CTR];
  logic        nxt_wr_msb   [ITB_NUM_CTR];
  logic        nxt_rd_msb   [ITB_NUM_CTR];
  logic        nxt_cnt_lat  [ITB_NUM_CTR];
  itb_cnt_t    nxt_latch    [ITB_NUM_CTR];
  logic        nxt_stat_lat [ITB_NUM_CTR];
  itb_byte_t   nxt_stat     [ITB_NUM_CTR];

  // bus answer and base register state
  logic [31:0] rdata_ff;
  logic        ack_ff;
  logic        fwd_ff;
  logic [15:0] base_ff;
  logic [31:0] nxt_rdata;
  logic        nxt_ack;
  logic        nxt_fwd;
  logic [15:0] nxt_base;

  // decode results shared by the next-state logic
  logic        ctrl_hit;
  logic        bt_addr_hit;
  logic        bt_en;
  logic [2:0]  port_hit;
  itb_byte_t   wbyte;
  logic        bt_ld;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // countdown matches a whole doubleword at the programmed base
  always_comb begin
    wbyte       = io_wdata_i[7:0];
    ctrl_hit    = (io_addr_i == ITB_PORT_CTRL);
    bt_en       = base_ff[ITB_BT_EN_BIT];
    bt_addr_hit = (io_addr_i[15:ITB_DW_LSB] == base_ff[15:ITB_DW_LSB]);
    for (int i = 0; i < ITB_NUM_CTR; i++) begin
      port_hit[i] = (io_addr_i == itb_port(i));
    end
    // partial-width writes cannot load half a count, so they are dropped
    bt_ld = io_wr_i && bt_addr_hit && bt_en && ((io_be_i & ITB_BE_LOW16) == ITB_BE_LOW16);
  end

  assign bt_link.ld     = bt_ld;
  assign bt_link.ld_val = io_wdata_i[15:0];
  assign bt_link.tick   = bt_tick_i;

  ////////////////////////////////////////////////////////////////////////////
  // counter next state: tick, control word, port write, port read

  always_comb begin
    logic     done;
    done = 1'b0;
    for (int i = 0; i < ITB_NUM_CTR; i++) begin
      nxt_rw[i]       = rw_ff[i];
      nxt_mode[i]     = mode_ff[i];
      nxt_bcd[i]      = bcd_ff[i];
      nxt_hold[i]     = hold_ff[i];
      nxt_ce[i]       = ce_ff[i];
      nxt_null[i]     = null_ff[i];
      nxt_wr_msb[i]   = wr_msb_ff[i];
      nxt_rd_msb[i]   = rd_msb_ff[i];
      nxt_cnt_lat[i]  = cnt_lat_ff[i];
      nxt_latch[i]    = latch_ff[i];
      nxt_stat_lat[i] = stat_lat_ff[i];
      nxt_stat[i]     = stat_ff[i];

      // counting element takes a pending count on the next tick, else steps
      if (ctr_tick_i[i]) begin
        if (null_ff[i]) begin
          nxt_ce[i]   = hold_ff[i];
          nxt_null[i] = 1'b0;
        end else begin
          nxt_ce[i]   = itb_dec(ce_ff[i], bcd_ff[i]);
        end
      end

      // control word: read-back, count latch or programming
      if (io_wr_i && ctrl_hit) begin
        if (wbyte[ITB_CW_SEL_HI:ITB_CW_SEL_LO] == ITB_SEL_RDBACK) begin
          if (wbyte[ITB_RB_CTR0 + i]) begin
            // a second latch before the read is ignored
            if (!wbyte[ITB_RB_NO_CNT] && !cnt_lat_ff[i]) begin
              nxt_latch[i]   = ce_ff[i];
              nxt_cnt_lat[i] = 1'b1;
            end
            if (!wbyte[ITB_RB_NO_STAT] && !stat_lat_ff[i]) begin
              nxt_stat[i]     = {ctr_out_i[i], null_ff[i], rw_ff[i], mode_ff[i], bcd_ff[i]};
              nxt_stat_lat[i] = 1'b1;
            end
          end
        end else if (wbyte[ITB_CW_SEL_HI:ITB_CW_SEL_LO] == 2'(i)) begin
          if (wbyte[ITB_CW_RW_HI:ITB_CW_RW_LO] == ITB_RW_LATCH) begin
            if (!cnt_lat_ff[i]) begin
              nxt_latch[i]   = ce_ff[i];
              nxt_cnt_lat[i] = 1'b1;
            end
          end else begin
            nxt_rw[i]       = wbyte[ITB_CW_RW_HI:ITB_CW_RW_LO];
            nxt_mode[i]     = wbyte[ITB_CW_MODE_HI:ITB_CW_MODE_LO];
            nxt_bcd[i]      = wbyte[ITB_CW_BCD];
            nxt_wr_msb[i]   = 1'b0;
            nxt_rd_msb[i]   = 1'b0;
            nxt_cnt_lat[i]  = 1'b0;
            nxt_stat_lat[i] = 1'b0;
          end
        end
      end

      // port write fills the holding register in the programmed byte order
      if (io_wr_i && port_hit[i]) begin
        case (rw_ff[i])
          ITB_RW_LSB: begin
            nxt_hold[i] = {8'h00, wbyte};
            nxt_null[i] = 1'b1;
          end
          ITB_RW_MSB: begin
            nxt_hold[i] = {wbyte, 8'h00};
            nxt_null[i] = 1'b1;
          end
          ITB_RW_BOTH: begin
            if (!wr_msb_ff[i]) begin
              nxt_hold[i][7:0] = wbyte;
              nxt_wr_msb[i]    = 1'b1;
            end else begin
              nxt_hold[i][15:8] = wbyte;
              nxt_wr_msb[i]     = 1'b0;
              nxt_null[i]       = 1'b1;
            end
          end
          default: begin
            nxt_hold[i] = hold_ff[i];
          end
        endcase
      end

      // port read: status first if latched, then latched count, else live
      if (io_rd_i && port_hit[i]) begin
        if (stat_lat_ff[i]) begin
          nxt_stat_lat[i] = 1'b0;
        end else begin
          done = 1'b0;
          case (rw_ff[i])
            ITB_RW_BOTH: begin
              nxt_rd_msb[i] = !rd_msb_ff[i];
              done          = rd_msb_ff[i];
            end
            default: begin
              done = 1'b1;
            end
          endcase
          if (done) begin
            nxt_cnt_lat[i] = 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: data, claim or pass-through

  // reads are answered one cycle after the strobe from flops
  always_comb begin
    itb_cnt_t rsrc;
    rsrc      = '0;
    nxt_rdata = '0;
    nxt_ack   = 1'b0;
    nxt_fwd   = 1'b0;
    nxt_base  = base_ff;
    if (cfg_base_wr_i) begin
      nxt_base = cfg_base_data_i;
    end
    if (io_rd_i || io_wr_i) begin
      if (ctrl_hit || (port_hit != 3'h0)) begin
        nxt_ack = 1'b1;
      end else if (bt_addr_hit) begin
        nxt_ack = bt_en;
        nxt_fwd = !bt_en;
      end
    end
    if (io_rd_i) begin
      for (int i = 0; i < ITB_NUM_CTR; i++) begin
        if (port_hit[i]) begin
          rsrc = cnt_lat_ff[i] ? latch_ff[i] : ce_ff[i];
          if (stat_lat_ff[i]) begin
            nxt_rdata[7:0] = stat_ff[i];
          end else if ((rw_ff[i] == ITB_RW_MSB) || ((rw_ff[i] == ITB_RW_BOTH) && rd_msb_ff[i])) begin
            nxt_rdata[7:0] = rsrc[15:8];
          end else begin
            nxt_rdata[7:0] = rsrc[7:0];
          end
        end
      end
      if (bt_addr_hit && bt_en && !ctrl_hit && (port_hit == 3'h0)) begin
        nxt_rdata = {16'h0000, bt_link.count};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ITB_NUM_CTR; i++) begin
        rw_ff[i]       <= ITB_RW_RST;
        mode_ff[i]     <= ITB_MODE_RST;
        bcd_ff[i]      <= 1'b0;
        hold_ff[i]     <= '0;
        ce_ff[i]       <= '0;
        null_ff[i]     <= 1'b0;
        wr_msb_ff[i]   <= 1'b0;
        rd_msb_ff[i]   <= 1'b0;
        cnt_lat_ff[i]  <= 1'b0;
        latch_ff[i]    <= '0;
        stat_lat_ff[i] <= 1'b0;
        stat_ff[i]     <= '0;
      end
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
      fwd_ff   <= 1'b0;
      base_ff  <= ITB_BT_BASE_RST;
    end else begin
      for (int i = 0; i < ITB_NUM_CTR; i++) begin
        rw_ff[i]       <= nxt_rw[i];
        mode_ff[i]     <= nxt_mode[i];
        bcd_ff[i]      <= nxt_bcd[i];
        hold_ff[i]     <= nxt_hold[i];
        ce_ff[i]       <= nxt_ce[i];
        null_ff[i]     <= nxt_null[i];
        wr_msb_ff[i]   <= nxt_wr_msb[i];
        rd_msb_ff[i]   <= nxt_rd_msb[i];
        cnt_lat_ff[i]  <= nxt_cnt_lat[i];
        latch_ff[i]    <= nxt_latch[i];
        stat_lat_ff[i] <= nxt_stat_lat[i];
        stat_ff[i]     <= nxt_stat[i];
      end
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      fwd_ff   <= nxt_fwd;
      base_ff  <= nxt_base;
    end
  end

  assign io_rdata_o   = rdata_ff;
  assign io_ack_o     = ack_ff;
  assign io_isa_fwd_o = fwd_ff;
  assign cfg_base_o   = base_ff;

endmodule : itb_timer_top

// ### hw/itb_pkg.sv
// shared constants and types for the interval timer port and firmware countdown block
package itb_pkg;

  // i/o map of the interval timer ports
  localparam logic [15:0] ITB_PORT_CTR0  = 16'h0040;
  localparam logic [15:0] ITB_PORT_CTR1  = 16'h0041;
  localparam logic [15:0] ITB_PORT_CTR2  = 16'h0042;
  localparam logic [15:0] ITB_PORT_CTRL  = 16'h0043;
  localparam int          ITB_NUM_CTR    = 3;

  // firmware countdown base register: reset location 78h, access disabled
  localparam logic [15:0] ITB_BT_BASE_RST = 16'h0078;
  localparam int          ITB_BT_EN_BIT   = 0;
  localparam int          ITB_DW_LSB      = 2;

  // control word fields
  localparam int          ITB_CW_SEL_HI  = 7;
  localparam int          ITB_CW_SEL_LO  = 6;
  localparam int          ITB_CW_RW_HI   = 5;
  localparam int          ITB_CW_RW_LO   = 4;
  localparam int          ITB_CW_MODE_HI = 3;
  localparam int          ITB_CW_MODE_LO = 1;
  localparam int          ITB_CW_BCD     = 0;
  localparam logic [1:0]  ITB_SEL_RDBACK = 2'h3;

  // read-back command fields (latch flags are active low)
  localparam int          ITB_RB_NO_CNT  = 5;
  localparam int          ITB_RB_NO_STAT = 4;
  localparam int          ITB_RB_CTR0    = 1;

  // byte-access selection codes
  localparam logic [1:0]  ITB_RW_LATCH   = 2'h0;
  localparam logic [1:0]  ITB_RW_LSB     = 2'h1;
  localparam logic [1:0]  ITB_RW_MSB     = 2'h2;
  localparam logic [1:0]  ITB_RW_BOTH    = 2'h3;

  // reset values of per-counter programming
  localparam logic [1:0]  ITB_RW_RST     = 2'h1;
  localparam logic [2:0]  ITB_MODE_RST   = 3'h0;

  // byte lanes that make a whole 16-bit count
  localparam logic [3:0]  ITB_BE_LOW16   = 4'h3;

  typedef logic [15:0] itb_cnt_t;
  typedef logic [7:0]  itb_byte_t;

endpackage : itb_pkg

// ### hw/itb_bt_if.sv
// link between the port decoder and the firmware countdown
`timescale 1ns/1ps
interface itb_bt_if;
  logic            ld;
  logic [15:0]     ld_val;
  logic            tick;
  logic [15:0]     count;

  modport ctl   (output ld, output ld_val, output tick, input count);
  modport timer (input ld, input ld_val, input tick, output count);
endinterface : itb_bt_if

// ### hw/itb_rst_sync.sv
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module itb_rst_sync (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  output logic      rstn_o
);
  logic meta_ff;
  logic sync_ff;

  // assert at once, release after two edges
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= 1'b1;
      sync_ff <= meta_ff;
    end
  end

  assign rstn_o = sync_ff;
endmodule : itb_rst_sync

// ### hw/itb_firmware_countdown.sv
// free-running 16-bit firmware countdown that freezes at zero
`timescale 1ns/1ps
module itb_firmware_countdown
  import itb_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  itb_bt_if.timer   bt
);
  itb_cnt_t cnt_ff;
  itb_cnt_t nxt_cnt;

  // load wins over a tick; the access-enable bit never gates counting
  always_comb begin
    nxt_cnt = cnt_ff;
    if (bt.ld) begin
      nxt_cnt = bt.ld_val;
    end else if (bt.tick && (cnt_ff != '0)) begin
      nxt_cnt = cnt_ff - itb_cnt_t'(1);
    end
  end

  // reset leaves the count at zero, frozen
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign bt.count = cnt_ff;
endmodule : itb_firmware_countdown

// ### dv/itb_timer_checker.sv
// concurrent checks on the host ports of the timer block
`timescale 1ns/1ps
module itb_timer_checker (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic [15:0] io_addr_i,
  input wire logic        io_rd_i,
  input wire logic        io_wr_i,
  input wire logic [31:0] io_wdata_i,
  input wire logic [3:0]  io_be_i,
  input wire logic        bt_tick_i,
  input wire logic        cfg_base_wr_i,
  input wire logic [15:0] cfg_base_data_i,
  input wire logic [31:0] io_rdata_o,
  input wire logic        io_ack_o,
  input wire logic        io_isa_fwd_o,
  input wire logic [15:0] cfg_base_o
);
  default clocking dck @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////
  // address decode seen from the pins; ports win over an overlapping base
  logic port_hit;
  logic bt_hit;
  assign port_hit = io_addr_i inside {[16'h0040:16'h0043]};
  assign bt_hit   = (io_addr_i[15:2] == cfg_base_o[15:2]) && !port_hit;

  // request steps
  sequence s_req;
    io_rd_i || io_wr_i;
  endsequence
  sequence s_bt_on;
    s_req ##0 bt_hit && cfg_base_o[0];
  endsequence
  sequence s_bt_off;
    s_req ##0 bt_hit && !cfg_base_o[0];
  endsequence
  sequence s_bt_load;
    s_bt_on ##0 io_wr_i && (io_be_i[1:0] == 2'h3);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  AST_PORT_ACK: assert property (s_req ##0 port_hit |=> io_ack_o && !io_isa_fwd_o)
    else $error("port access not claimed");
  AST_BT_CLAIM: assert property (s_bt_on |=> io_ack_o && !io_isa_fwd_o)
    else $error("enabled countdown access not claimed");
  AST_BT_PASS: assert property (s_bt_off |=> io_isa_fwd_o && !io_ack_o)
    else $error("disabled countdown access not passed on");
  AST_BT_HIGH: assert property (s_bt_on ##0 io_rd_i |=> io_rdata_o[31:16] == 16'h0000)
    else $error("countdown upper half not zero");
  AST_IDLE: assert property (!(io_rd_i || io_wr_i) |=> !io_ack_o && !io_isa_fwd_o)
    else $error("answer without a request");
  AST_RDATA_IDLE: assert property (!io_rd_i |=> io_rdata_o == 32'h0000_0000)
    else $error("read data outside a read answer");
  AST_BASE: assert property (cfg_base_wr_i |=> cfg_base_o == $past(cfg_base_data_i))
    else $error("base register not written");
  // no reference tick between load and read, so the read must show the load
  AST_BT_LOAD: assert property (s_bt_load ##1 !bt_tick_i ##1 s_bt_on ##0 io_rd_i
    |=> io_rdata_o[15:0] == $past(io_wdata_i[15:0], 3))
    else $error("countdown load not seen on read");
endmodule : itb_timer_checker

// ### dv/itb_host_model.sv
// host model issuing single-cycle i/o reads and writes
`timescale 1ns/1ps
module itb_host_model (
  input  wire logic        mclk_i,
  input  wire logic        ack_i,
  input  wire logic        fwd_i,
  input  wire logic [31:0] rdata_i,
  output logic      [15:0] addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  be_o
);
  // idle bus values; strobes low
  initial begin
    addr_o  = 16'hFFFF;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 32'h0000_0000;
    be_o    = 4'h0;
  end

  // strobe for one edge, answer sampled the cycle after; released lines invert
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic ack, output logic fwd, output logic [31:0] q);
    @(posedge mclk_i);
    #1;
    addr_o  = a;
    wdata_o = d;
    be_o    = b;
    rd_o    = !w;
    wr_o    = w;
    @(posedge mclk_i);
    #1;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
    ack     = ack_i;
    fwd     = fwd_i;
    q       = rdata_i;
  endtask : acc
endmodule : itb_host_model

// ### dv/interval_timer_readback_firmware_countdown_bench.sv
// self-checking bench for the timer port block
`timescale 1ns/1ps
module interval_timer_readback_firmware_countdown_bench
  import itb_pkg::*;
;
  logic        mclk;
  logic        rstn;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        io_wr;
  logic [31:0] io_wdata;
  logic [3:0]  io_be;
  logic [2:0]  ctr_tick;
  logic [2:0]  ctr_out;
  logic        bt_tick;
  logic        base_wr;
  logic [15:0] base_data;
  logic [31:0] io_rdata;
  logic        io_ack;
  logic        io_fwd;
  logic [15:0] cfg_base;
  logic        ack_s;
  logic        fwd_s;
  logic [31:0] q_s;
  int          bad_count;
  int          compares;
  int          cycles;

  itb_timer_top DUT (.mclk_i(mclk), .rstn_i(rstn), .io_addr_i(io_addr), .io_rd_i(io_rd),
    .io_wr_i(io_wr), .io_wdata_i(io_wdata), .io_be_i(io_be), .ctr_tick_i(ctr_tick),
    .ctr_out_i(ctr_out), .bt_tick_i(bt_tick), .cfg_base_wr_i(base_wr), .cfg_base_data_i(base_data),
    .io_rdata_o(io_rdata), .io_ack_o(io_ack), .io_isa_fwd_o(io_fwd), .cfg_base_o(cfg_base));
  itb_host_model host (.mclk_i(mclk), .ack_i(io_ack), .fwd_i(io_fwd), .rdata_i(io_rdata),
    .addr_o(io_addr), .rd_o(io_rd), .wr_o(io_wr), .wdata_o(io_wdata), .be_o(io_be));

  ////////////////////////////////////////////////////////////////////////
  // clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard; the tests need well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
    host.acc(1'b1, a, d, b, ack_s, fwd_s, q_s);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input string nm, input logic [31:0] e);
    host.acc(1'b0, a, 32'h0000_0000, 4'hF, ack_s, fwd_s, q_s);
    chk(nm, e, q_s);
  endtask : rdc

  // sel is {countdown tick, counter ticks}; held high for n edges
  task automatic pulse(input int n, input logic [3:0] sel);
    @(posedge mclk);
    #1;
    {bt_tick, ctr_tick} = sel;
    repeat (n) @(posedge mclk);
    #1;
    {bt_tick, ctr_tick} = 4'h0;
  endtask : pulse

  task automatic setbase(input logic [15:0] v);
    @(posedge mclk);
    #1;
    base_wr   = 1'b1;
    base_data = v;
    @(posedge mclk);
    #1;
    base_wr   = 1'b0;
  endtask : setbase

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rstn, bt_tick, ctr_tick, ctr_out, base_wr, base_data} = '0;
    {bad_count, compares, cycles} = '0;
    repeat (6) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge mclk);
    chk("base reset", {16'h0, ITB_BT_BASE_RST}, {16'h0, cfg_base});
    // countdown disabled after reset: passed on, not claimed
    wr(16'h0078, 32'h0000_0009, 4'hF);
    chk("off fwd ack", 32'h2, {30'h0, fwd_s, ack_s});
    setbase(16'h0079);
    rdc(16'h0078, "bt reset", 32'h0000_0000);
    wr(16'h0078, 32'hABCD_0005, 4'hF);
    rdc(16'h0078, "bt load", 32'h0000_0005);
    pulse(3, 4'h8);
    rdc(16'h0078, "bt step", 32'h0000_0002);
    pulse(8, 4'h8);
    rdc(16'h0078, "bt freeze", 32'h0000_0000);
    wr(16'h0078, 32'hFFFF_1234, 4'h3);
    wr(16'h0078, 32'h0000_0777, 4'h1);
    rdc(16'h0078, "bt 16bit", 32'h0000_1234);
    // count runs on with access off; then the register moves
    setbase(16'h0078);
    wr(16'h0078, 32'h0000_0009, 4'hF);
    pulse(4, 4'h8);
    setbase(16'h0101);
    rdc(16'h0100, "bt relocated", 32'h0000_1230);
    rdc(16'h0078, "old base", 32'h0000_0000);
    chk("old base fwd ack", 32'h0, {30'h0, fwd_s, ack_s});
    // counter 0: low then high, mode 2; status before and after the load
    wr(ITB_PORT_CTRL, 32'h34, 4'hF);
    wr(ITB_PORT_CTR0, 32'h78, 4'hF);
    wr(ITB_PORT_CTR0, 32'h56, 4'hF);
    ctr_out = 3'b001;
    wr(ITB_PORT_CTRL, 32'hE2, 4'hF);
    rdc(ITB_PORT_CTR0, "status pending", 32'hF4);
    pulse(1, 4'h1);
    wr(ITB_PORT_CTRL, 32'hC2, 4'hF);
    rdc(ITB_PORT_CTR0, "status loaded", 32'hB4);
    rdc(ITB_PORT_CTR0, "latched low", 32'h78);
    rdc(ITB_PORT_CTR0, "latched high", 32'h56);
    // access codes 1 to 3 and every mode code echoed by counter 1; never written, so bit 6 stays 0
    for (int m = 0; m < 8; m++) begin
      for (int r = 1; r < 4; r++) begin
        ctr_out = {1'b0, m[0], 1'b0};
        wr(ITB_PORT_CTRL, {24'h0, 2'b01, r[1:0], m[2:0], m[0]}, 4'hF);
        wr(ITB_PORT_CTRL, 32'hE4, 4'hF);
        rdc(ITB_PORT_CTR1, "status code", {24'h0, m[0], 1'b0, r[1:0], m[2:0], m[0]});
        chk("status fields", {25'h0, m[0], r[1:0], m[2:0], m[0]}, {25'h0, q_s[7], q_s[5:0]});
      end
    end
    // counter 1 is left low then high in decimal: 1000 steps to 0999
    wr(ITB_PORT_CTR1, 32'h00, 4'hF);
    wr(ITB_PORT_CTR1, 32'h10, 4'hF);
    pulse(2, 4'h2);
    wr(ITB_PORT_CTRL, 32'h40, 4'hF);
    rdc(ITB_PORT_CTR1, "bcd low", 32'h99);
    rdc(ITB_PORT_CTR1, "bcd high", 32'h09);
    // counter 2: low only via count latch, then high only read live
    wr(ITB_PORT_CTRL, 32'h90, 4'hF);
    wr(ITB_PORT_CTR2, 32'hAB, 4'hF);
    pulse(1, 4'h4);
    wr(ITB_PORT_CTRL, 32'h80, 4'hF);
    rdc(ITB_PORT_CTR2, "low only", 32'hAB);
    wr(ITB_PORT_CTRL, 32'hA0, 4'hF);
    wr(ITB_PORT_CTR2, 32'hCD, 4'hF);
    pulse(1, 4'h4);
    rdc(ITB_PORT_CTR2, "high only live", 32'hCD);
    pulse(1, 4'h4);
    rdc(ITB_PORT_CTR2, "binary step", 32'hCC);
    complete_run();
  end
endmodule : interval_timer_readback_firmware_countdown_bench

bind itb_timer_top itb_timer_checker u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .io_addr_i(io_addr_i),
  .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_be_i(io_be_i), .bt_tick_i(bt_tick_i),
  .cfg_base_wr_i(cfg_base_wr_i), .cfg_base_data_i(cfg_base_data_i), .io_rdata_o(io_rdata_o),
  .io_ack_o(io_ack_o), .io_isa_fwd_o(io_isa_fwd_o), .cfg_base_o(cfg_base_o));
